/* File: rtl/aes_seq.v */
// Adapter equipment sequencer: object construction, communication mode, errors
//
// Behaviour
// - With objects held, send startup notice, await acceptance, enter normal operation.
// - Without objects, send per-object inquiry, await each reply, repeat for all.
// - After all objects, send inquiry completion notice and await its acceptance.
// - Then send startup notice, await acceptance, only then enter normal operation.
// - In communication mode, issue status access request and await its reply.
// - Answer each status notification request within the timeout. Requests arriving while our command awaits its reply are dropped unanswered.
// - Answer each object access request within the timeout. Requests arriving while our command awaits its reply are dropped unanswered.
// - In normal operation with no command or reply pending, a frame received with error is dropped and an error notice is sent.
// - Error frame answering our command counts as failure; resend as on timeout.
// - Frequent errors load error code, set error status, start error handling.
// - No second request while a reply to the first is pending.
// - Fresh request arriving before our reply is sent is discarded.
// - Multi Get: reply directly unless fetch-service property; else status access first.
// - Multi Set: reply directly unless store-service property; else status access first.
// - Response timeout is three seconds, both directions.
`include "aes_seq_regs.vh"

module aes_seq #(
  parameter [31:0] TOUT_CYCLES = `AES_TOUT_ONE_CYCLES
) (
  input  wire       I_SYS_CLK,
  input  wire       I_SYS_RST,
  // Objects-held strap and object count for construction
  input  wire       I_OBJ_HELD,
  input  wire [7:0] I_OBJ_COUNT,
  // Received frame codes from the framer
  input  wire [7:0] I_RX_CODE,
  input  wire       I_RX_VALID,
  input  wire       I_RX_ERR,
  output wire       O_RX_READY,
  // Transmit frame request to the framer
  output reg  [7:0] O_TX_CODE,
  output reg  [7:0] O_TX_INDEX,
  output reg        O_TX_VALID,
  input  wire       I_TX_READY,
  // Composite Get/Set from the network side
  input  wire       I_NET_GET,
  input  wire       I_NET_SET,
  input  wire       I_NET_FETCH_SVC,
  input  wire       I_NET_STORE_SVC,
  output reg        O_NET_BUSY,
  output reg        O_NET_DONE,
  output reg        O_NET_FAIL,
  // Status and error properties
  output reg        O_NORMAL_OP,
  output reg        O_XCHG_FAIL,
  output reg  [7:0] O_ERR_CODE,
  output reg  [7:0] O_ERR_STATUS,
  output reg        O_ERR_HANDLE
);
  // **************************************************
  // States
  // **************************************************
  localparam [2:0] ST_INIT   = 3'h0;
  localparam [2:0] ST_SEND   = 3'h1;
  localparam [2:0] ST_WAIT   = 3'h2;
  localparam [2:0] ST_NORMAL = 3'h3;
  localparam [2:0] ST_REPLY  = 3'h4;
  localparam [2:0] ST_HALT   = 3'h5;

  // Purpose of the outstanding command
  localparam [1:0] PH_INQ    = 2'h0;
  localparam [1:0] PH_DONE   = 2'h1;
  localparam [1:0] PH_START  = 2'h2;
  localparam [1:0] PH_ACCESS = 2'h3;

  reg  [2:0]  state_r;
  reg  [1:0]  phase_r;
  reg  [7:0]  obj_idx_r;
  reg  [31:0] tmr_r;
  reg  [1:0]  retry_r;
  reg  [3:0]  err_cnt_r;
  reg  [7:0]  cmd_r;

  wire [7:0]  fifo_code;
  wire        fifo_valid;
  wire        fifo_take;
  wire [7:0]  rx_in;

  // Errored frames are replaced by the error code in the queue
  assign rx_in = I_RX_ERR ? `AES_FT_COMM_ERROR : I_RX_CODE;

  aes_seq_fifo #(
    .WIDTH (`AES_FIFO_WIDTH),
    .DEPTH (`AES_FIFO_DEPTH),
    .AW    (`AES_FIFO_AW)
  ) u_fifo (
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_SYS_RST),
    .i_data  (rx_in),
    .i_valid (I_RX_VALID),
    .o_ready (O_RX_READY),
    .o_data  (fifo_code),
    .o_valid (fifo_valid),
    .i_ready (fifo_take)
  );

  // **************************************************
  // Helpers
  // **************************************************
  function [7:0] reply_of;
    input [7:0] code;
    begin
      reply_of = code | 8'h80;
    end
  endfunction

  // Queue drains while a frame can be considered; otherwise it holds up to 32 frames before the sender stalls
  assign fifo_take = fifo_valid && (state_r == ST_WAIT || state_r == ST_NORMAL
                     || state_r == ST_REPLY);

  wire tx_fire = O_TX_VALID && I_TX_READY;
  wire tout    = (tmr_r == 32'h0);

  // **************************************************
  // Sequencer
  // **************************************************
  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      state_r      <= ST_INIT;
      phase_r      <= PH_START;
      obj_idx_r    <= 8'h00;
      tmr_r        <= 32'h0;
      retry_r      <= 2'h0;
      err_cnt_r    <= 4'h0;
      cmd_r        <= 8'h00;
      O_TX_CODE    <= 8'h00;
      O_TX_INDEX   <= 8'h00;
      O_TX_VALID   <= 1'b0;
      O_NET_BUSY   <= 1'b0;
      O_NET_DONE   <= 1'b0;
      O_NET_FAIL   <= 1'b0;
      O_NORMAL_OP  <= 1'b0;
      O_XCHG_FAIL  <= 1'b0;
      O_ERR_CODE   <= `AES_ERR_CODE_NONE;
      O_ERR_STATUS <= `AES_ERR_STATUS_NONE;
      O_ERR_HANDLE <= 1'b0;
    end else begin
      O_NET_DONE  <= 1'b0;
      O_NET_FAIL  <= 1'b0;
      O_XCHG_FAIL <= 1'b0;
      if (tx_fire) begin
        O_TX_VALID <= 1'b0;
      end
      if (!tout) begin
        tmr_r <= tmr_r - 32'h1;
      end
      if (err_cnt_r >= `AES_ERR_FREQ_LIMIT) begin
        O_ERR_CODE   <= `AES_ERR_CODE_COMM;
        O_ERR_STATUS <= `AES_ERR_STATUS_OCCURRED;
        O_ERR_HANDLE <= 1'b1;
      end
      case (state_r)
        ST_INIT: begin
          // Strap is read one edge after release, not under reset
          if (I_OBJ_HELD || I_OBJ_COUNT == 8'h00) begin
            phase_r <= PH_START;
            cmd_r   <= `AES_FT_STARTUP_NOTICE;
          end else begin
            phase_r <= PH_INQ;
            cmd_r   <= `AES_FT_INQUIRY_REQ;
          end
          obj_idx_r <= 8'h00;
          retry_r   <= 2'h0;
          state_r   <= ST_SEND;
        end
        ST_SEND: begin
          // One command at a time: issued only from here, cleared in any state once the framer accepts it
          if (!O_TX_VALID) begin
            O_TX_CODE  <= cmd_r;
            O_TX_INDEX <= obj_idx_r;
            O_TX_VALID <= 1'b1;
            tmr_r      <= TOUT_CYCLES;
            state_r    <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (fifo_take && fifo_code == reply_of(cmd_r)) begin
            retry_r <= 2'h0;
            case (phase_r)
              PH_INQ: begin
                if (obj_idx_r + 8'h01 < I_OBJ_COUNT) begin
                  obj_idx_r <= obj_idx_r + 8'h01;
                  cmd_r     <= `AES_FT_INQUIRY_REQ;
                end else begin
                  phase_r <= PH_DONE;
                  cmd_r   <= `AES_FT_INQ_DONE_NOTICE;
                end
                state_r <= ST_SEND;
              end
              PH_DONE: begin
                phase_r <= PH_START;
                cmd_r   <= `AES_FT_STARTUP_NOTICE;
                state_r <= ST_SEND;
              end
              PH_START: begin
                O_NORMAL_OP <= 1'b1;
                state_r     <= ST_NORMAL;
              end
              default: begin
                O_NET_DONE <= 1'b1;
                O_NET_BUSY <= 1'b0;
                state_r    <= ST_NORMAL;
              end
            endcase
          end else if ((fifo_take && fifo_code == `AES_FT_COMM_ERROR) || (tout && !O_TX_VALID)) begin
            // Error frame or silence: failed exchange, resend alike
            O_XCHG_FAIL <= 1'b1;
            if (fifo_take && fifo_code == `AES_FT_COMM_ERROR) begin
              err_cnt_r <= (err_cnt_r == 4'hF) ? err_cnt_r : err_cnt_r + 4'h1;
            end
            if (retry_r < `AES_RETRY_MAX) begin
              retry_r <= retry_r + 2'h1;
              state_r <= ST_SEND;
            end else if (phase_r == PH_ACCESS) begin
              O_NET_FAIL <= 1'b1;
              O_NET_BUSY <= 1'b0;
              retry_r    <= 2'h0;
              state_r    <= ST_NORMAL;
            end else begin
              state_r <= ST_HALT;
            end
          end
          // Other frames while waiting are dropped
        end
        ST_NORMAL: begin
          if (fifo_take && fifo_code == `AES_FT_COMM_ERROR) begin
            err_cnt_r <= (err_cnt_r == 4'hF) ? err_cnt_r : err_cnt_r + 4'h1;
            O_TX_CODE  <= `AES_FT_COMM_ERROR;
            O_TX_VALID <= 1'b1;
            state_r    <= ST_REPLY;
          end else if (fifo_take && (fifo_code == `AES_FT_STATUS_NTF_REQ
                       || fifo_code == `AES_FT_OBJ_ACC_REQ)) begin
            O_TX_CODE  <= reply_of(fifo_code);
            O_TX_VALID <= 1'b1;
            state_r    <= ST_REPLY;
          end else if ((I_NET_GET && !I_NET_FETCH_SVC) || (I_NET_SET && !I_NET_STORE_SVC)) begin
            O_NET_DONE <= 1'b1;
          end else if (I_NET_GET || I_NET_SET) begin
            O_NET_BUSY <= 1'b1;
            phase_r    <= PH_ACCESS;
            cmd_r      <= `AES_FT_STATUS_ACC_REQ;
            retry_r    <= 2'h0;
            state_r    <= ST_SEND;
          end
        end
        ST_REPLY: begin
          // Fresh requests before our reply leaves are thrown away
          if (tx_fire) begin
            state_r <= ST_NORMAL;
          end
        end
        ST_HALT: begin
          O_ERR_CODE   <= `AES_ERR_CODE_COMM;
          O_ERR_STATUS <= `AES_ERR_STATUS_OCCURRED;
          O_ERR_HANDLE <= 1'b1;
        end
        default: begin
          state_r <= ST_INIT;
        end
      endcase
    end
  end

endmodule

// **************************************************
// Receive FIFO: valid/ready on both sides
// **************************************************
module aes_seq_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_data,
  input  wire             i_valid,
  output wire             o_ready,
  output wire [WIDTH-1:0] o_data,
  output wire             o_valid,
  input  wire             i_ready
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW:0]      wp_r;
  reg [AW:0]      rp_r;
  reg             ready_r;
  wire [AW:0]     wp_nxt;
  wire [AW:0]     rp_nxt;
  wire            push;
  wire            pop;
  wire            full;
  wire            empty;

  // Full when the pointers meet with opposite wrap bits
  function is_full;
    input [AW:0] wp;
    input [AW:0] rp;
    begin
      is_full = (wp[AW-1:0] == rp[AW-1:0]) && (wp[AW] != rp[AW]);
    end
  endfunction

  assign full    = is_full(wp_r, rp_r);
  assign empty   = (wp_r == rp_r);
  assign push    = i_valid && !full;
  assign pop     = i_ready && !empty;
  assign wp_nxt  = push ? wp_r + 1'b1 : wp_r;
  assign rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
  // Ready taken from the next pointers, so the port comes straight from a flop
  assign o_ready = ready_r;
  assign o_valid = ~empty;
  assign o_data  = mem_r[rp_r[AW-1:0]];

  always @(posedge i_clk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= i_data;
    end
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      wp_r    <= {(AW+1){1'b0}};
      rp_r    <= {(AW+1){1'b0}};
      ready_r <= 1'b1;
    end else begin
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      ready_r <= !is_full(wp_nxt, rp_nxt);
    end
  end
endmodule

/* File: rtl/aes_seq_fifo.v */
// Receive FIFO module is kept beside the sequencer so that all logic sits in one file

/* File: rtl/aes_seq_regs.vh */
// Constants of the adapter equipment sequencer: frame codes, timing, thresholds
`ifndef AES_SEQ_REGS_VH
`define AES_SEQ_REGS_VH

// Frame type codes on the link (request/notice out, reply in and vice versa)
`define AES_FT_STARTUP_NOTICE    8'h01
`define AES_FT_STARTUP_ACK       8'h81
`define AES_FT_INQUIRY_REQ       8'h02
`define AES_FT_INQUIRY_RSP       8'h82
`define AES_FT_INQ_DONE_NOTICE   8'h03
`define AES_FT_INQ_DONE_ACK      8'h83
`define AES_FT_STATUS_ACC_REQ    8'h04
`define AES_FT_STATUS_ACC_RSP    8'h84
`define AES_FT_STATUS_NTF_REQ    8'h05
`define AES_FT_STATUS_NTF_RSP    8'h85
`define AES_FT_OBJ_ACC_REQ       8'h06
`define AES_FT_OBJ_ACC_RSP       8'h86
`define AES_FT_COMM_ERROR        8'hEE

// Reply-class bit of a frame code
`define AES_FT_REPLY_BIT         7

// Error code loaded into the error property on frequent errors
`define AES_ERR_CODE_COMM        8'h01
`define AES_ERR_STATUS_OCCURRED  8'h41
`define AES_ERR_STATUS_NONE      8'h42
`define AES_ERR_CODE_NONE        8'h00

// Response timeout: 3 s at a 50 ns clock
`define AES_TOUT_ONE_NS          32'hB2D05E00
`define AES_CLK_PERIOD_NS        32'h32
`define AES_TOUT_ONE_CYCLES      (`AES_TOUT_ONE_NS / `AES_CLK_PERIOD_NS)

// Retries per command and error count that marks errors as frequent
`define AES_RETRY_MAX            2'h2
`define AES_ERR_FREQ_LIMIT       4'h8

// FIFO shape
`define AES_FIFO_WIDTH           8
`define AES_FIFO_DEPTH           32
`define AES_FIFO_AW              5

`endif

/* File: test/aes_appl_model.sv */
// Appliance model answering the sequencer's frames
`include "aes_seq_regs.vh"
module aes_appl_model (
  input  wire logic       i_clk,
  input  wire logic       i_hold,
  input  wire logic [7:0] i_tx_code,
  input  wire logic       i_tx_valid,
  output logic            o_tx_ready,
  output logic      [7:0] o_rx_code,
  output logic            o_rx_valid,
  output logic            o_rx_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] seen[$];
  logic [8:0] q[$];
  int         mode = 0;
  int         dly = 0;
  int         wt = 0;
  int         err_ind = 0;
  logic       ph = 1'b0;
  logic       go;
  initial begin
    o_tx_ready = 1'b1;
    o_rx_code = 8'h00;
    o_rx_valid = 1'b0;
    o_rx_err = 1'b0;
  end
  // ****
  // Answers
  // ****
  // Never starts a request of its own, so none can overlap a pending one
  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready) begin
      seen.push_back(i_tx_code);
      // Error notices from the adapter are counted for an error indication
      if (i_tx_code == `AES_FT_COMM_ERROR) begin
        err_ind++;
      end
      if (!i_tx_code[`AES_FT_REPLY_BIT] && mode != 1) begin
        q.push_back(mode == 2 ? {1'b0, `AES_FT_COMM_ERROR} : {1'b0, i_tx_code | 8'h80});
        if (mode == 2) mode = 0;
      end
    end
  end
  // Idle code line toggles so a stale code never looks like a frame
  always @(negedge i_clk) begin
    go = q.size() != 0 && wt >= dly;
    ph <= ~ph;
    o_tx_ready <= !i_hold && !(dly > 0 && ph);
    o_rx_valid <= go;
    if (go) begin
      {o_rx_err, o_rx_code} <= q.pop_front();
      wt <= 0;
    end else begin
      o_rx_err <= 1'b0;
      o_rx_code <= ~o_rx_code;
      wt <= (q.size() != 0) ? wt + 1 : 0;
    end
  end
endmodule

/* File: test/aes_seq_checker.sv */
// Port assertions of the adapter equipment sequencer
`include "aes_seq_regs.vh"
module aes_seq_checker #(
  parameter [31:0] TOUT_CYCLES = 32'h32
) (
  input wire logic       I_SYS_CLK,
  input wire logic       I_SYS_RST,
  input wire logic       I_RX_VALID,
  input wire logic       I_RX_ERR,
  input wire logic       O_RX_READY,
  input wire logic [7:0] O_TX_CODE,
  input wire logic       O_TX_VALID,
  input wire logic       I_TX_READY,
  input wire logic       O_NET_BUSY,
  input wire logic       O_NET_DONE,
  input wire logic       O_NORMAL_OP,
  input wire logic       O_XCHG_FAIL,
  input wire logic [7:0] O_ERR_CODE,
  input wire logic [7:0] O_ERR_STATUS,
  input wire logic       O_ERR_HANDLE
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Relations
  // ****
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_SYS_RST);
  a_tx_hold: assert property (O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_CODE))
    else $error("tx request changed");
  a_reset_vals: assert property ($past(I_SYS_RST) |-> !O_NORMAL_OP && O_ERR_STATUS == `AES_ERR_STATUS_NONE)
    else $error("bad reset state");
  a_err_pair: assert property (O_ERR_HANDLE |-> O_ERR_STATUS == `AES_ERR_STATUS_OCCURRED &&
    O_ERR_CODE == `AES_ERR_CODE_COMM) else $error("error props mismatch");
  a_done_pulse: assert property (O_NET_DONE |=> !O_NET_DONE)
    else $error("done too long");
  a_fail_pulse: assert property (O_XCHG_FAIL |=> !O_XCHG_FAIL)
    else $error("fail too long");
  a_err_notice: assert property (O_NORMAL_OP && I_RX_VALID && I_RX_ERR && O_RX_READY |->
    ##[1:40] O_TX_VALID && O_TX_CODE == `AES_FT_COMM_ERROR) else $error("no error notice");
  a_busy_asks: assert property ($rose(O_NET_BUSY) |-> ##[0:3] O_TX_VALID && O_TX_CODE == `AES_FT_STATUS_ACC_REQ)
    else $error("busy without access");
  a_stat_normal: assert property (O_TX_VALID && O_TX_CODE == `AES_FT_STATUS_ACC_REQ |-> O_NORMAL_OP)
    else $error("access outside normal");
endmodule
bind aes_seq aes_seq_checker #(.TOUT_CYCLES(TOUT_CYCLES)) aes_seq_checker_inst (
  .I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_RX_VALID(I_RX_VALID), .I_RX_ERR(I_RX_ERR),
  .O_RX_READY(O_RX_READY), .O_TX_CODE(O_TX_CODE), .O_TX_VALID(O_TX_VALID), .I_TX_READY(I_TX_READY),
  .O_NET_BUSY(O_NET_BUSY), .O_NET_DONE(O_NET_DONE), .O_NORMAL_OP(O_NORMAL_OP), .O_XCHG_FAIL(O_XCHG_FAIL),
  .O_ERR_CODE(O_ERR_CODE), .O_ERR_STATUS(O_ERR_STATUS), .O_ERR_HANDLE(O_ERR_HANDLE));

/* File: test/aes_seq_tb_top.sv */
// Self-checking bench of the adapter equipment sequencer
`include "aes_seq_regs.vh"
module aes_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, held = 0, get = 0, set = 0, fsvc = 0, ssvc = 0, hold = 0;
  logic  [7:0] cnt = 8'h00;
  logic  [7:0] rx_code, tx_code, tx_index, ecode, estat;
  logic        rx_valid, rx_err, rx_ready, tx_valid, tx_ready, busy, done, nfail, normal, xfail, ehandle;
  logic  [7:0] exp[$];
  logic  [7:0] idx[$];
  logic  [8:0] req[3];
  logic  [7:0] rsp[3];
  logic [31:0] rnd = 32'h496A;
  int          fails = 0, compares = 0, n, e0;
  aes_seq #(.TOUT_CYCLES(32'h32)) aes_seq_inst (
    .I_SYS_CLK(clk), .I_SYS_RST(rst), .I_OBJ_HELD(held), .I_OBJ_COUNT(cnt), .I_RX_CODE(rx_code),
    .I_RX_VALID(rx_valid), .I_RX_ERR(rx_err), .O_RX_READY(rx_ready), .O_TX_CODE(tx_code), .O_TX_INDEX(tx_index),
    .O_TX_VALID(tx_valid), .I_TX_READY(tx_ready), .I_NET_GET(get), .I_NET_SET(set), .I_NET_FETCH_SVC(fsvc),
    .I_NET_STORE_SVC(ssvc), .O_NET_BUSY(busy), .O_NET_DONE(done), .O_NET_FAIL(nfail), .O_NORMAL_OP(normal),
    .O_XCHG_FAIL(xfail), .O_ERR_CODE(ecode), .O_ERR_STATUS(estat), .O_ERR_HANDLE(ehandle));
  aes_appl_model aes_appl_model_inst (
    .i_clk(clk), .i_hold(hold), .i_tx_code(tx_code), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .o_rx_code(rx_code), .o_rx_valid(rx_valid), .o_rx_err(rx_err));
  initial forever #25 clk = ~clk;
  // Object index of every accepted inquiry, in order
  always @(posedge clk) begin
    if (tx_valid && tx_ready && tx_code == `AES_FT_INQUIRY_REQ) begin
      idx.push_back(tx_index);
    end
  end
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task chk(input string what, input logic [7:0] e, input logic [7:0] got);
    compares++;
    if (got !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, e, got);
    end
  endtask
  task stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Waits: 0 normal, 1 failed exchange, 2 composite done, 4 composite gave up, 3 k frames sent
  task automatic wait_on(input int sel, input int k);
    n = 0;
    while (!(sel == 0 ? normal === 1'b1 : sel == 1 ? xfail === 1'b1 : sel == 2 ? done === 1'b1 :
             sel == 4 ? nfail === 1'b1 : aes_appl_model_inst.seen.size() >= k)) begin
      if (n++ == 300) begin
        fails++;
        $display("[ERR] wait %0d expected 1 seen 0", sel);
        stop_test();
      end
      @(negedge clk);
    end
  endtask
  task seq_is(input string what);
    chk(what, 8'(exp.size()), 8'(aes_appl_model_inst.seen.size()));
    foreach (exp[i]) chk(what, exp[i], aes_appl_model_inst.seen[i]);
  endtask
  task start(input logic h, input logic [7:0] c, input int m);
    rst = 1;
    held = h;
    cnt = c;
    rnd = xs(rnd);
    aes_appl_model_inst.mode = m;
    aes_appl_model_inst.dly = int'(rnd[1:0]);
    repeat (10) @(negedge clk);
    aes_appl_model_inst.seen.delete();
    aes_appl_model_inst.q.delete();
    idx.delete();
    rst = 0;
    exp = {};
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    @(negedge clk);
    start(1'b1, 8'h00, 0);
    @(negedge clk);
    chk("err status", `AES_ERR_STATUS_NONE, estat);
    chk("normal", 8'h00, {7'h00, normal});
    chk("rx ready", 8'h01, {7'h00, rx_ready});
    wait_on(0, 0);
    exp = '{`AES_FT_STARTUP_NOTICE};
    seq_is("startup");
    for (int c = 0; c < 4; c++) begin
      start(1'b0, 8'(c), 0);
      wait_on(0, 0);
      repeat (c) exp.push_back(`AES_FT_INQUIRY_REQ);
      if (c > 0) exp.push_back(`AES_FT_INQ_DONE_NOTICE);
      exp.push_back(`AES_FT_STARTUP_NOTICE);
      seq_is("construct");
      chk("index count", 8'(c), 8'(idx.size()));
      foreach (idx[j]) chk("index", 8'(j), idx[j]);
    end
    $display("test construct done");
    start(1'b1, 8'h00, 1);
    wait_on(1, 0);
    chk("timeout", 8'h01, {7'h00, n >= 50 && n <= 60});
    aes_appl_model_inst.mode = 0;
    wait_on(0, 0);
    exp = '{`AES_FT_STARTUP_NOTICE, `AES_FT_STARTUP_NOTICE};
    seq_is("retry");
    start(1'b1, 8'h00, 2);
    exp = '{`AES_FT_STARTUP_NOTICE, `AES_FT_STARTUP_NOTICE};
    wait_on(0, 0);
    seq_is("resend");
    $display("test retry done");
    req = '{{1'b0, `AES_FT_STATUS_NTF_REQ}, {1'b0, `AES_FT_OBJ_ACC_REQ}, {1'b1, rnd[7:0]}};
    rsp = '{`AES_FT_STATUS_NTF_RSP, `AES_FT_OBJ_ACC_RSP, `AES_FT_COMM_ERROR};
    for (int i = 0; i < 3; i++) begin
      aes_appl_model_inst.seen.delete();
      aes_appl_model_inst.q.push_back(req[i]);
      wait_on(3, 1);
      chk("reply time", 8'h01, {7'h00, n < 50});
      exp = '{rsp[i]};
      seq_is("answer");
    end
    aes_appl_model_inst.seen.delete();
    hold = 1;
    aes_appl_model_inst.q.push_back(req[0]);
    repeat (2) @(negedge clk);
    aes_appl_model_inst.q.push_back(req[1]);
    repeat (10) @(negedge clk);
    hold = 0;
    repeat (20) @(negedge clk);
    exp = '{rsp[0]};
    seq_is("discard");
    $display("test answer done");
    for (int i = 0; i < 4; i++) begin
      aes_appl_model_inst.seen.delete();
      get = !i[1];
      set = i[1];
      fsvc = i[0] ^ i[1];
      ssvc = !fsvc;
      wait_on(2, 0);
      get = 0;
      set = 0;
      exp = {};
      if (i[0]) exp.push_back(`AES_FT_STATUS_ACC_REQ);
      seq_is("composite");
      repeat (3) @(negedge clk);
    end
    aes_appl_model_inst.seen.delete();
    aes_appl_model_inst.mode = 1;
    get = 1;
    fsvc = 1;
    wait_on(4, 0);
    get = 0;
    aes_appl_model_inst.mode = 0;
    chk("busy", 8'h00, {7'h00, busy});
    exp = '{`AES_FT_STATUS_ACC_REQ, `AES_FT_STATUS_ACC_REQ, `AES_FT_STATUS_ACC_REQ};
    seq_is("give up");
    $display("test composite done");
    aes_appl_model_inst.seen.delete();
    e0 = aes_appl_model_inst.err_ind;
    for (int i = 1; i <= 8; i++) begin
      rnd = xs(rnd);
      aes_appl_model_inst.q.push_back({1'b1, rnd[7:0]});
      wait_on(3, i);
    end
    repeat (3) @(negedge clk);
    chk("err code", `AES_ERR_CODE_COMM, ecode);
    chk("err status", `AES_ERR_STATUS_OCCURRED, estat);
    chk("err handle", 8'h01, {7'h00, ehandle});
    chk("err frames", 8'h08, 8'(aes_appl_model_inst.err_ind - e0));
    $display("test errors done");
    stop_test();
  end
endmodule
